// ===== core/paged_config_pkg.sv
// Purpose: Shared constants and types for the paged configuration register bank.
// Assumes: Page 0 holds the full configuration map; other pages expose only the page selector.
// Notes:   Offsets, reset values and access kinds are indexed by table slot, not by offset.
package paged_config_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          NUM_REGS       = 48;
    localparam int          IDX_W          = 6;
    localparam logic [7:0]  OFS_PAGE_SEL   = 8'h00;
    localparam logic [7:0]  OFS_SOFT_RESET = 8'h01;
    localparam int          SOFT_RESET_BIT = 0;
    localparam logic [7:0]  PAGE_ZERO      = 8'h00;
    localparam int          NUM_RO         = 4;

    // Offset of each stored register, in table order.
    localparam logic [7:0] REG_OFFSET [NUM_REGS] = '{
        8'h00, 8'h01, 8'h02, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0a,
        8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h13, 8'h14, 8'h15, 8'h16,
        8'h1f, 8'h20, 8'h21, 8'h22, 8'h29, 8'h2a, 8'h2b, 8'h2f,
        8'h32, 8'h33, 8'h36, 8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e,
        8'h3f, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h48,
        8'h49, 8'h4a, 8'h4d, 8'h4e, 8'h4f, 8'h6b, 8'h6c, 8'h6d};

    // Power-on default of each stored register, in table order.
    localparam logic [7:0] REG_RESET [NUM_REGS] = '{
        8'h00, 8'h00, 8'h00, 8'h05, 8'h30, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h01, 8'h02, 8'h03, 8'h02, 8'h48, 8'hff, 8'h10,
        8'h40, 8'h00, 8'h22, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc9,
        8'h80, 8'h00, 8'h00, 8'h00, 8'hc9, 8'h80, 8'h00, 8'hc9,
        8'h80, 8'h00, 8'hc9, 8'h80, 8'h00, 8'h01, 8'h40, 8'h7b};

    // Table slots of the read-only status registers, loaded from status inputs.
    localparam logic [IDX_W-1:0] RO_SLOT [NUM_RO] = '{6'd14, 6'd21, 6'd23, 6'd26};

    // ------------------------------------------------------------------
    // Serial target port
    // ------------------------------------------------------------------
    localparam logic [3:0]  BITS_PER_BYTE  = 4'd8;
    localparam logic [6:0]  DEFAULT_TARGET = 7'h2a;

    typedef enum logic [3:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_ADDR_ACK,
        BUS_REG,
        BUS_REG_ACK,
        BUS_WDATA,
        BUS_WDATA_ACK,
        BUS_RDATA,
        BUS_RACK
    } bus_state_t;

endpackage

// ===== core/paged_config_register_bank.sv
// Purpose: Page 0 configuration register bank reached through a serial two-wire target port.
// Assumes: scl_in and sda_in come from pins; status inputs come from logic on mclk_in.
//          Status strobes last one clock each.
// Notes:   The pins are oversampled at 50 MHz, so bus clocks far below that rate only.
//          Bus phases must last four clocks or more.
//          Ack rises about three clocks after an SCL fall.
//          Read bits change about three clocks after a fall.
//          A soft reset beats a status load in one cycle.
//          Only the page selector exists off page 0.
//          Reserved bits are stored as written, except those of the soft reset register, which is never stored.
//          Unmapped offsets read as zero.
//          A foreign address is ignored until a start.
//
// Behaviour
// RULE1: Host treats unlisted page 0 offsets as reserved and leaves them unchanged.
// RULE2: Offset 0x0 holds an 8-bit page number; writing n selects page n.
// RULE3: Writing 1 to bit 0 at offset 0x1 restores every register default.
// RULE4: The soft reset bit clears itself and always reads back zero.
// RULE5: Host writes only zeros to bits 7 to 1 of the soft reset register.
// RULE6: Interrupt mask register at 0x33 holds 0xff after any reset.
// RULE7: Slot registers 0xb to 0xe reset to 0x00, 0x01, 0x02, 0x03.
// RULE8: Each channel's third register resets to 0xc9, fourth to 0x80.
// RULE9: Port clock monitor status at 0x15 reads 0xff after reset.
// RULE10: Page 0 is selected after reset; page selector sits at offset 0 everywhere.
// RULE11: Registers are 8 bits, addressed by 8-bit offset within current page.
// RULE12: Multi-byte writes advance to the next register per byte until stop or start.
module paged_config_register_bank
    import paged_config_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = DEFAULT_TARGET
) (
    input  wire logic                          mclk_in,
    input  wire logic                          rst_n_in,
    input  wire logic                          scl_in,
    input  wire logic                          sda_in,
    output logic                               sda_out,
    output logic                               sda_oe_out,
    input  wire logic [NUM_RO-1:0]             status_load_in,
    input  wire logic [NUM_RO-1:0][7:0]        status_value_in,
    output logic [7:0]                         page_out,
    output logic [NUM_REGS-1:0][7:0]           regs_out,
    output logic                               soft_reset_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Whole bank state.
    typedef struct packed {
        // Clock pin stages.
        logic                      scl_a;
        logic                      scl_b;
        logic                      scl_c;
        // Data pin stages.
        logic                      sda_a;
        logic                      sda_b;
        logic                      sda_c;
        // Byte engine.
        bus_state_t                st;
        // Bit count in the byte.
        logic [3:0]                bits;
        // Byte in flight.
        logic [7:0]                shift;
        logic                      rd_mode;
        // Register pointer.
        logic [7:0]                ptr;
        // High while pulling SDA.
        logic                      sda_drive;
        // One-cycle reset marker.
        logic                      srst_pulse;
        // Contents by table slot.
        logic [NUM_REGS-1:0][7:0]  regs;
    } bank_state_t;

    // Current and next state.
    bank_state_t q;
    bank_state_t d;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------

    // Finds the table slot of an offset; the top bit flags a mapped offset.
    // Linear search over one table.
    function automatic logic [IDX_W:0] find_slot(input logic [7:0] ofs);
        logic [IDX_W:0] res;
        res = '0;
        // Offsets are unique.
        for (int i = 0; i < NUM_REGS; i++) begin
            if (REG_OFFSET[i] == ofs) begin
                res = {1'b1, IDX_W'(i)};
            end
        end

        return res;
    endfunction

    // Tells whether a table slot is a status register that the host cannot write.
    // They still read their value.
    function automatic logic is_ro_slot(input logic [IDX_W-1:0] slot);
        logic res;
        res = 1'b0;
        for (int k = 0; k < NUM_RO; k++) begin
            if (RO_SLOT[k] == slot) begin
                res = 1'b1;
            end
        end

        return res;
    endfunction

    // Power-on contents of the whole table.
    // Both resets share it.
    function automatic logic [NUM_REGS-1:0][7:0] default_regs();
        logic [NUM_REGS-1:0][7:0] res;
        res = '0;
        for (int i = 0; i < NUM_REGS; i++) begin
            res[i] = REG_RESET[i];                                          // RULE6 RULE7 RULE8 RULE9
        end

        return res;
    endfunction

    // Value returned for a read of an offset in the current page.
    // Unmapped offsets and every non-zero offset outside page 0 read as zero.
    // Reads have no side effect.
    function automatic logic [7:0] read_byte(input logic [7:0] ofs,
                                             input logic [NUM_REGS-1:0][7:0] regs);
        logic [IDX_W:0] hit;
        logic [7:0]     res;
        hit = find_slot(ofs);
        // Page select answers on every page.
        res = 8'h00;
        if (ofs == OFS_PAGE_SEL) begin
            res = regs[0];                                                  // RULE10
        end else if (regs[0] == PAGE_ZERO && hit[IDX_W]) begin
            res = regs[hit[IDX_W-1:0]];                                     // RULE11
        end

        return res;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    // All behaviour lives here; the flop process only registers the copy.
    always_comb begin
        logic           scl_rise;
        logic           scl_fall;
        logic           bus_start;
        logic           bus_stop;
        logic [IDX_W:0] hit;
        logic [7:0]     rd_val;
        logic [7:0]     nxt_ptr;

        // Defaults cover every path.
        scl_rise  = 1'b0;
        scl_fall  = 1'b0;
        bus_start = 1'b0;
        bus_stop  = 1'b0;
        hit       = '0;
        rd_val    = 8'h00;
        nxt_ptr   = 8'h00;

        d         = q;
        // The pulse lasts one cycle.
        d.srst_pulse = 1'b0;

        // Two flops per pin before any logic; the third stage is only a delayed copy.
        // Stages reset to the idle level.
        d.scl_a = scl_in;
        d.scl_b = q.scl_a;
        d.scl_c = q.scl_b;
        d.sda_a = sda_in;
        d.sda_b = q.sda_a;
        d.sda_c = q.sda_b;

        // Edges use stages two and three.
        scl_rise  = q.scl_b & ~q.scl_c;
        scl_fall  = ~q.scl_b & q.scl_c;
        // Conditions need SCL high twice.
        bus_start = q.scl_b & q.scl_c & ~q.sda_b & q.sda_c;
        bus_stop  = q.scl_b & q.scl_c & q.sda_b & ~q.sda_c;

        // Status registers follow their producers on each load strobe that no reset in the same cycle overrides.
        // Host writes to them are dropped.
        for (int k = 0; k < NUM_RO; k++) begin
            if (status_load_in[k]) begin
                d.regs[RO_SLOT[k]] = status_value_in[k];
            end
        end

        // A start or a stop overrides whatever byte was in flight.
        // The pointer survives a restart.
        if (bus_start) begin
            d.st        = BUS_ADDR;                                         // RULE12
            d.bits      = '0;
            d.sda_drive = 1'b0;
        end else if (bus_stop) begin
            d.st        = BUS_IDLE;                                         // RULE12
            d.sda_drive = 1'b0;
        end else begin
            case (q.st)
                // Idle: pin released.
                BUS_IDLE: begin
                    d.sda_drive = 1'b0;
                end

                // Receive: shift on rise.
                BUS_ADDR, BUS_REG, BUS_WDATA: begin
                    if (scl_rise) begin
                        d.shift = {q.shift[6:0], q.sda_b};
                        d.bits  = q.bits + 4'd1;
                    end

                    if (scl_fall && q.bits == BITS_PER_BYTE) begin
                        // Byte done: act and ack.
                        d.bits = '0;
                        if (q.st == BUS_ADDR) begin
                            // A foreign address leaves the pins alone until the next start.
                            if (q.shift[7:1] == TARGET_ADDR) begin
                                // Our address: note direction.
                                d.rd_mode   = q.shift[0];
                                d.sda_drive = 1'b1;
                                d.st        = BUS_ADDR_ACK;
                            end else begin
                                d.st = BUS_IDLE;
                            end
                        end else if (q.st == BUS_REG) begin
                            // Offset loads the pointer.
                            d.ptr       = q.shift;                          // RULE11
                            d.sda_drive = 1'b1;
                            d.st        = BUS_REG_ACK;
                        end else begin
                            hit = find_slot(q.ptr);
                            // Any page may change page.
                            if (q.ptr == OFS_PAGE_SEL) begin
                                d.regs[0] = q.shift;                        // RULE2 RULE10
                            end else if (q.regs[0] == PAGE_ZERO) begin
                                if (q.ptr == OFS_SOFT_RESET) begin
                                    // The request bit itself is never stored, so it reads zero.
                                    if (q.shift[SOFT_RESET_BIT]) begin
                                        d.regs       = default_regs();      // RULE3 RULE4 RULE10
                                        d.srst_pulse = 1'b1;
                                    end
                                end else if (hit[IDX_W] && !is_ro_slot(hit[IDX_W-1:0])) begin
                                    // Writable slot.
                                    d.regs[hit[IDX_W-1:0]] = q.shift;
                                end
                            end

                            // Wraps at 8 bits.
                            d.ptr       = q.ptr + 8'd1;                     // RULE12
                            d.sda_drive = 1'b1;
                            d.st        = BUS_WDATA_ACK;
                        end
                    end
                end

                // Read or await offset.
                BUS_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (q.rd_mode) begin
                            // First byte from the pointer.
                            rd_val      = read_byte(q.ptr, q.regs);
                            d.shift     = rd_val;
                            d.sda_drive = ~rd_val[7];
                            d.bits      = '0;
                            d.st        = BUS_RDATA;
                        end else begin
                            d.sda_drive = 1'b0;
                            d.st        = BUS_REG;
                        end
                    end
                end

                // Ack ends on a fall.
                BUS_REG_ACK, BUS_WDATA_ACK: begin
                    if (scl_fall) begin
                        d.sda_drive = 1'b0;
                        d.st        = BUS_WDATA;
                    end
                end

                // Transmit: bit per fall.
                BUS_RDATA: begin
                    if (scl_rise) begin
                        d.bits = q.bits + 4'd1;
                    end

                    if (scl_fall) begin
                        if (q.bits == BITS_PER_BYTE) begin
                            d.sda_drive = 1'b0;
                            d.st        = BUS_RACK;
                        end else begin
                            // Next bit, MSB first.
                            d.shift     = {q.shift[6:0], 1'b0};
                            d.sda_drive = ~q.shift[6];
                        end
                    end
                end

                BUS_RACK: begin
                    // A host NACK ends the read; only a new start revives the port.
                    if (scl_rise && q.sda_b) begin
                        // Released line: NACK.
                        d.st = BUS_IDLE;
                    end else if (scl_fall) begin
                        // Ack: fetch next byte.
                        nxt_ptr     = q.ptr + 8'd1;
                        rd_val      = read_byte(nxt_ptr, q.regs);
                        d.ptr       = nxt_ptr;
                        d.shift     = rd_val;
                        d.sda_drive = ~rd_val[7];
                        d.bits      = '0;
                        d.st        = BUS_RDATA;
                    end
                end

                // Unused codes go idle.
                default: begin
                    d.st        = BUS_IDLE;
                    d.sda_drive = 1'b0;
                end
            endcase
        end

        // Synchronous reset: pins assumed idle high, page 0 and all defaults restored.
        // Last, so it wins.
        if (!rst_n_in) begin
            d            = '0;
            // Pins idle high.
            d.scl_a      = 1'b1;
            d.scl_b      = 1'b1;
            d.scl_c      = 1'b1;
            d.sda_a      = 1'b1;
            d.sda_b      = 1'b1;
            d.sda_c      = 1'b1;
            d.st         = BUS_IDLE;
            // Shared default image.
            d.regs       = default_regs();                                  // RULE6 RULE7 RULE8 RULE9 RULE10
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Single register stage for the whole bank.
    // Reset sits in the logic above.
    always_ff @(posedge mclk_in) begin
        q <= d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Open-drain data pin: only ever pulls low, enable set while pulling.
    // Value fixed; enable decides.
    assign sda_out        = 1'b0;
    assign sda_oe_out     = q.sda_drive;

    // Register views.
    assign page_out       = q.regs[0];
    assign regs_out       = q.regs;

    // Reset pulse for the rest of the device.
    assign soft_reset_out = q.srst_pulse;

endmodule

// ===== verif/i2c_host_model.sv
// Purpose: Behavioural two-wire bus host that drives the bank's target port.
// Assumes: SDA has a pull-up and SCL is driven by this host alone.
// Notes:   Every bus phase lasts eight clocks, far inside the port's limit.
module i2c_host_model (
    input  wire logic mclk_in,
    input  wire logic sda_oe_in,
    input  wire logic sda_drv_in,
    output logic      scl_out,
    output logic      sda_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic pull_q; // High while the host pulls SDA low.

    // The line is low when either party pulls it, otherwise the pull-up wins.
    assign sda_out = !(pull_q || (sda_oe_in && !sda_drv_in));

    initial begin
        scl_out = 1'b1;
        pull_q = 1'b0;
    end

    // Changes land just after an edge so no synchroniser ever races the host.
    task automatic tick();
        repeat (8) @(posedge mclk_in);
        #1;
    endtask

    // Start or repeated start: SDA falls while SCL is high.
    task automatic start();
        pull_q = 1'b0;
        tick();
        scl_out = 1'b1;
        tick();
        pull_q = 1'b1;
        tick();
        scl_out = 1'b0;
        tick();
    endtask

    // Stop: SDA rises while SCL is high, then the bus is left free.
    task automatic stop();
        pull_q = 1'b1;
        tick();
        scl_out = 1'b1;
        tick();
        pull_q = 1'b0;
        tick();
    endtask

    // Eight bits of b, then the ninth bit driven as last; returns what the line carried.
    task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] r, output logic ack9);
        logic [8:0] d;
        logic [8:0] s;
        d = {b, last};
        s = '0;
        for (int i = 8; i >= 0; i--) begin
            pull_q = !d[i];
            tick();
            scl_out = 1'b1;
            tick();
            s = {s[7:0], sda_out};
            scl_out = 1'b0;
            tick();
        end
        r = s[8:1];
        ack9 = s[0];
    endtask
endmodule

// ===== verif/paged_config_register_bank_asserts.sv
// Purpose: Port assertions for the paged configuration register bank.
// Assumes: Status loads never coincide with a soft reset.
// Notes:   Slots follow the package table order.
module reg_bank_checker
    import paged_config_pkg::*;
(
    input wire logic                     mclk_in,
    input wire logic                     rst_n_in,
    input wire logic [7:0]               page_out,
    input wire logic [NUM_REGS-1:0][7:0] regs_out,
    input wire logic                     soft_reset_out
);
    default clocking dc @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    a_page_mirror: assert property (page_out == regs_out[0])
        else $error("page output differs from register zero");
    a_soft_reads_zero: assert property (regs_out[1] == 8'h00)
        else $error("soft reset register not zero");
    a_soft_pulse_one: assert property (soft_reset_out |=> !soft_reset_out [*8])
        else $error("soft reset pulse too long");
    a_soft_page_zero: assert property (soft_reset_out |-> page_out == 8'h00 && regs_out[3] == 8'h05)
        else $error("soft reset left page or defaults");
    a_slot_defaults: assert property (soft_reset_out |-> regs_out[8] == 8'h00 && regs_out[9] == 8'h01 &&
        regs_out[10] == 8'h02 && regs_out[11] == 8'h03) else $error("slot defaults wrong");
    a_chan_defaults: assert property (soft_reset_out |-> regs_out[31] == 8'hc9 && regs_out[32] == 8'h80 &&
        regs_out[36] == 8'hc9 && regs_out[37] == 8'h80 && regs_out[39] == 8'hc9 && regs_out[40] == 8'h80 &&
        regs_out[42] == 8'hc9 && regs_out[43] == 8'h80) else $error("channel defaults wrong");
    a_monitor_default: assert property (soft_reset_out |-> regs_out[14] == 8'hff)
        else $error("clock monitor default wrong");
    a_mask_after_reset: assert property ($rose(rst_n_in) |-> regs_out[25] == 8'hff && page_out == 8'h00)
        else $error("mask or page wrong after reset");
endmodule

bind paged_config_register_bank reg_bank_checker chk_i (.mclk_in, .rst_n_in, .page_out, .regs_out, .soft_reset_out);

// ===== verif/paged_config_register_bank_tb.sv
// Purpose: Self-checking bench for the paged configuration register bank.
// Assumes: The host model keeps every bus phase at eight clocks.
// Notes:   Values are read over the bus and also watched on regs_out.
module paged_config_register_bank_tb
    import paged_config_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [6:0] DEV = 7'h31; // Target address; the value is arbitrary.
    logic                     mclk_in, rst_n_in, scl, sda, sda_out, sda_oe_out, soft_reset_out, k, nak;
    logic [NUM_RO-1:0]        status_load_in;
    logic [NUM_RO-1:0][7:0]   status_value_in;
    logic [7:0]               page_out, o, s, e, w, a, r;
    logic [NUM_REGS-1:0][7:0] regs_out;
    logic [31:0]              v;
    int                       fails, n_tests, n_sr;
    // Offset, slot, reset value, value written, value held afterwards.
    logic [39:0] rows [17] = '{40'h02_02_00_5a_5a, 40'h05_03_05_a5_a5, 40'h15_0e_ff_00_ff, 40'h6d_2f_7b_84_84,
        40'h0b_08_00_13_13, 40'h0c_09_01_14_14, 40'h0d_0a_02_15_15, 40'h0e_0b_03_16_16,
        40'h3e_1f_c9_12_12, 40'h3f_20_80_34_34, 40'h43_24_c9_56_56, 40'h44_25_80_78_78,
        40'h48_27_c9_9a_9a, 40'h49_28_80_bc_bc, 40'h4d_2a_c9_de_de, 40'h4e_2b_80_f0_f0,
        40'h33_19_ff_0f_0f};

    paged_config_register_bank #(.TARGET_ADDR(DEV)) uut (.mclk_in, .rst_n_in, .scl_in(scl), .sda_in(sda),
        .sda_out, .sda_oe_out, .status_load_in, .status_value_in, .page_out, .regs_out, .soft_reset_out);
    i2c_host_model host (.mclk_in, .sda_oe_in(sda_oe_out), .sda_drv_in(sda_out), .scl_out(scl), .sda_out(sda));

    // ------------------------------------------------------------------
    // Clock, pulse counting and watchdog
    // ------------------------------------------------------------------
    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) if (soft_reset_out === 1'b1) n_sr++;
    // The run needs about 40000 clocks; over twice that means a hang.
    initial begin
        repeat (90000) @(posedge mclk_in);
        fails++;
        conclude();
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic put(input logic [7:0] b);
        host.xfer(b, 1'b1, r, k);
        nak |= k;
    endtask
    // Write n bytes from d, most significant first, in one transfer.
    task automatic wr(input logic [7:0] ofs, input int n, input logic [31:0] d);
        nak = 1'b0;
        host.start();
        put({DEV, 1'b0});
        put(ofs);
        for (int i = n - 1; i >= 0; i--) put(d[8*i +: 8]);
        host.stop();
        chk("write ack", 0, nak);
    endtask
    // Read n bytes; the host acknowledges all but the last.
    task automatic rd(input logic [7:0] ofs, input int n, output logic [31:0] q);
        nak = 1'b0;
        q = '0;
        host.start();
        put({DEV, 1'b0});
        put(ofs);
        host.start();
        put({DEV, 1'b1});
        for (int i = n; i > 0; i--) begin
            host.xfer(8'hff, i == 1, r, k);
            q = {q[23:0], r};
        end
        host.stop();
        chk("read ack", 0, nak);
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n_in = 1'b0;
        status_load_in = '0;
        status_value_in = '0;
        repeat (16) @(posedge mclk_in);
        #1 rst_n_in = 1'b1;
        repeat (4) @(posedge mclk_in);
        for (int i = 0; i < 17; i++) begin
            {o, s, e, w, a} = rows[i];
            chk("reset value", e, regs_out[s]);
            rd(o, 1, v);
            chk("read back", e, v);
            wr(o, 1, {24'h0, w});
            chk("after write", a, regs_out[s]);
        end
        // Page changes, including the top page number and a write off page 0.
        wr(8'h00, 1, 32'h05);
        chk("page", 8'h05, page_out);
        wr(8'h33, 1, 32'h00);
        chk("off page write", 8'h0f, regs_out[25]);
        rd(8'h00, 1, v);
        chk("page reg on page 5", 8'h05, v);
        wr(8'h00, 1, 32'hff);
        chk("page 255", 8'hff, page_out);
        wr(8'h00, 1, 32'h00);
        chk("page 0", 8'h00, page_out);
        // Sequential write and read over the slot registers.
        wr(8'h0b, 4, 32'ha1a2a3a4);
        for (int j = 0; j < 4; j++) chk("burst slot", 8'ha1 + 8'(j), regs_out[8+j]);
        rd(8'h0b, 4, v);
        chk("burst read", 32'ha1a2a3a4, v);
        // Soft reset: zero does nothing, one restores every default once.
        wr(8'h01, 1, 32'h00);
        chk("zero write", 8'ha1, regs_out[8]);
        n_sr = 0;
        wr(8'h01, 1, 32'h01);
        chk("reset pulses", 1, n_sr);
        for (int i = 0; i < NUM_REGS; i++) chk("default", REG_RESET[i], regs_out[i]);
        rd(8'h01, 1, v);
        chk("soft bit", 8'h00, v);
        // Status loads, then a pin reset from a nonzero page.
        for (int j = 0; j < NUM_RO; j++) begin
            @(posedge mclk_in);
            #1 status_load_in = 4'(1 << j);
            status_value_in[j] = 8'h5a + 8'(j);
            @(posedge mclk_in);
            #1 status_load_in = '0;
            chk("status load", 8'h5a + 8'(j), regs_out[RO_SLOT[j]]);
        end
        rd(8'h15, 1, v);
        chk("monitor read", 8'h5a, v);
        wr(8'h00, 1, 32'h07);
        @(posedge mclk_in);
        #1 rst_n_in = 1'b0;
        repeat (2) @(posedge mclk_in);
        #1 rst_n_in = 1'b1;
        chk("monitor reset", 8'hff, regs_out[14]);
        chk("mask reset", 8'hff, regs_out[25]);
        chk("page reset", 8'h00, page_out);
        repeat (4) @(posedge mclk_in);
        // A foreign address is not acknowledged; an unlisted offset reads zero.
        host.start();
        host.xfer({DEV ^ 7'h01, 1'b0}, 1'b1, r, k);
        host.stop();
        chk("foreign ack", 1, k);
        rd(8'h03, 1, v);
        chk("unlisted read", 8'h00, v);
        conclude();
    end
endmodule
